// ### pfa_map.vh
// Register map, commands and field positions of the flash array control.
`ifndef PFA_MAP_VH
`define PFA_MAP_VH
`define PF_R_ADDR 6'h00
`define PF_R_DATA 6'h04
`define PF_R_CMD 6'h08
`define PF_R_STAT 6'h0C
`define PF_R_ARRAY 6'h10
`define PF_R_CFG 6'h14
`define PF_R_LOCK 6'h18
`define PF_R_PIDX 6'h1C
`define PF_R_PDATA 6'h20
`define PF_C_PROG 4'h1
`define PF_C_ERASE 4'h2
`define PF_C_SUSP 4'h3
`define PF_C_RESUME 4'h4
`define PF_C_LOCK 4'h5
`define PF_C_UNLOCK 4'h6
`define PF_C_LOCKDN 4'h7
`define PF_C_CLRST 4'h8
`define PF_S_READY 7
`define PF_S_ESUSP 6
`define PF_S_EERR 5
`define PF_S_PERR 4
`define PF_S_VPP 3
`define PF_S_PSUSP 2
`define PF_S_LOCK 1
`define PF_ST_RST 8'h80
`define PF_P_CE 0
`define PF_P_OE 1
`define PF_P_CS1 2
`define PF_P_CS2 3
`define PF_P_WP 4
`define PF_P_VPP 5
`define PF_P_BCLK 6
`define PF_PART_LSB 18
`define PF_MAIN_LSB 15
`define PF_PARAM_LSB 12
`define PF_SUB_PARAM 4'h8
`define PF_PROT_USER 3'h4
`define PF_SYNC_IDLE 7'h07
`define PF_TMR_LAST 32'h00000001
`endif

// ### pfa_ctrl.v
// Partitioned flash array control: partitions, locking, suspend and reads.
//
// Added by the designer: strobed register access and the placing of the registers.
`include "pfa_map.vh"
module pfa_ctrl #(
  parameter AW = 21,
  parameter TOP_PARAM = 1,
  parameter PROG_CYC = 200,
  parameter ERASE_CYC = 25000,
  parameter BURST_LAT = 3,
  parameter [63:0] UID = 64'h0123456789ABCDEF // Arbitrary value.
) (
  input wire clk_i,
  input wire rst_i,
  input wire [5:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire [15:0] arr_rdata_i,
  output reg [AW-1:0] arr_addr_o,
  output reg [15:0] arr_wdata_o,
  output reg arr_prog_o,
  output reg arr_erase_o,
  output reg arr_erase_param_o,
  input wire ce_n_i,
  input wire oe_n_i,
  input wire sram_cs1_n_i,
  input wire sram_cs2_i,
  input wire wp_n_i,
  input wire vpp_ok_i,
  input wire bclk_i,
  output reg wait_o,
  output reg auto_power_saving_o,
  output reg flash_standby_o,
  output reg sram_standby_o
);
  // Partition count, block count and the split region follow the width.
  localparam NPART = 1 << (AW - `PF_PART_LSB);
  localparam PW = AW - `PF_PART_LSB;
  localparam NBLK = NPART * 16;
  localparam BW = PW + 4;
  localparam [PW-1:0] PPART = TOP_PARAM ? {PW{1'b1}} : {PW{1'b0}};
  localparam [2:0] PREG = TOP_PARAM ? 3'h7 : 3'h0;
  // One-hot engine states.
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_RUN = 3'b010;
  localparam [2:0] S_SUSP = 3'b100;

  // True when a word address falls in the split region of the parameter
  // partition, where the small blocks live.
  function in_preg;
    input [AW-1:0] a;
    begin
      in_preg = a[AW-1:`PF_PART_LSB] == PPART &&
                a[`PF_PART_LSB-1:`PF_MAIN_LSB] == PREG;
    end
  endfunction

  // Block number of a word address: partition, then a sub index in it.
  function [BW-1:0] blk_of;
    input [AW-1:0] a;
    begin
      if (in_preg(a)) begin
        blk_of = {a[AW-1:`PF_PART_LSB], 1'b1,
                  a[`PF_MAIN_LSB-1:`PF_PARAM_LSB]};
      end else begin
        blk_of = {a[AW-1:`PF_PART_LSB], 1'b0,
                  a[`PF_PART_LSB-1:`PF_MAIN_LSB]};
      end
    end
  endfunction

  // Synchronised pins, registers, lock bits and the engine state.
  reg [6:0] s1_ff;
  reg [6:0] s2_ff;
  reg bclk_d_ff;
  reg oe_d_ff;
  reg [AW-1:0] addr_ff;
  reg [15:0] data_ff;
  reg burst_ff;
  reg [2:0] pidx_ff;
  reg [15:0] prot_ff [0:3];
  reg [3:0] prot_used_ff;
  reg [NBLK-1:0] lock_ff;
  reg [NBLK-1:0] ldn_ff;
  // One status byte per partition, so each reads its own state.
  reg [7:0] pst_ff [0:NPART-1];
  reg [2:0] st_ff;
  reg op_erase_ff;
  reg [PW-1:0] op_part_ff;
  reg [31:0] tmr_ff;
  reg [7:0] lat_ff;
  integer i;

  // Pins in synchroniser order, then decodes of the held address.
  wire [6:0] pins = {bclk_i, vpp_ok_i, wp_n_i, sram_cs2_i, sram_cs1_n_i,
    oe_n_i, ce_n_i};
  wire vpp_low = ~s2_ff[`PF_P_VPP];
  wire wr_cmd = wr_i && addr_i == `PF_R_CMD;
  wire [3:0] cmd = wdata_i[3:0];
  wire [BW-1:0] blk = blk_of(addr_ff);
  wire [PW-1:0] apart = addr_ff[AW-1:`PF_PART_LSB];
  wire blk_ok = ~blk[3] || in_preg(addr_ff);
  wire blk_lock = lock_ff[blk] | vpp_low;
  wire part_busy = st_ff == S_RUN && op_part_ff == apart;
  wire bedge = s2_ff[`PF_P_BCLK] & ~bclk_d_ff;
  wire rd_act = ~s2_ff[`PF_P_CE] & ~s2_ff[`PF_P_OE];

  // Two-flop synchronisers for every pin from outside the clock domain.
  // Reset rests the select, output-enable and burst clock stages at their idle levels and wp_n_i and vpp_ok_i low, so that no false
  // select or output-enable edge follows a reset.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= `PF_SYNC_IDLE;
      s2_ff <= `PF_SYNC_IDLE;
      bclk_d_ff <= 1'b0;
      oe_d_ff <= 1'b1;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      bclk_d_ff <= s2_ff[`PF_P_BCLK];
      oe_d_ff <= s2_ff[`PF_P_OE];
    end
  end

  // Plain registers written from the register port.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_ff <= {AW{1'b0}};
      data_ff <= 16'h0000;
      burst_ff <= 1'b0;
      pidx_ff <= 3'h0;
    end else if (wr_i) begin
      // Each offset updates only its own register.
      if (addr_i == `PF_R_ADDR) begin
        addr_ff <= wdata_i[AW-1:0];
      end
      if (addr_i == `PF_R_DATA) begin
        data_ff <= wdata_i[15:0];
      end
      if (addr_i == `PF_R_CFG) begin
        burst_ff <= wdata_i[0];
      end
      if (addr_i == `PF_R_PIDX) begin
        pidx_ff <= wdata_i[2:0];
      end
    end
  end

  // User half of the protection register; each word takes one write.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prot_used_ff <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        prot_ff[i] <= 16'hFFFF;
      end
    end else if (wr_i && addr_i == `PF_R_PDATA && pidx_ff[2] &&
                 !prot_used_ff[pidx_ff[1:0]] && !vpp_low) begin
      // Indexes four to seven are the user half; the rest is the identifier.
      prot_ff[pidx_ff[1:0]] <= wdata_i[15:0];
      prot_used_ff[pidx_ff[1:0]] <= 1'b1;
    end
  end

  // Block lock and lock-down bits; every block starts locked.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_ff <= {NBLK{1'b1}};
      ldn_ff <= {NBLK{1'b0}};
    end else if (wr_cmd && blk_ok) begin
      // Lock-down also locks; unlock needs no lock-down or a high guard.
      if (cmd == `PF_C_LOCK) begin
        lock_ff[blk] <= 1'b1;
      end
      if (cmd == `PF_C_LOCKDN) begin
        lock_ff[blk] <= 1'b1;
        ldn_ff[blk] <= 1'b1;
      end
      if (cmd == `PF_C_UNLOCK && (!ldn_ff[blk] || s2_ff[`PF_P_WP])) begin
        lock_ff[blk] <= 1'b0;
      end
    end
  end

  // Program and erase engine with suspend, and per-partition status.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      // Nothing runs after reset and every partition reads ready.
      st_ff <= S_IDLE;
      op_erase_ff <= 1'b0;
      op_part_ff <= {PW{1'b0}};
      tmr_ff <= 32'h00000000;
      arr_addr_o <= {AW{1'b0}};
      arr_wdata_o <= 16'h0000;
      arr_prog_o <= 1'b0;
      arr_erase_o <= 1'b0;
      arr_erase_param_o <= 1'b0;
      for (i = 0; i < NPART; i = i + 1) begin
        pst_ff[i] <= `PF_ST_RST;
      end
    end else begin
      // Completion strobes last one cycle.
      arr_prog_o <= 1'b0;
      arr_erase_o <= 1'b0;
      // Clear keeps only ready; a status set later in this process wins.
      if (wr_cmd && cmd == `PF_C_CLRST) begin
        pst_ff[apart] <= pst_ff[apart] & `PF_ST_RST;
      end
      // Idle starts work, run counts it down, suspend holds the count.
      case (st_ff)
        S_IDLE: begin
          if (wr_cmd && (cmd == `PF_C_PROG || cmd == `PF_C_ERASE)) begin
            // Lockout is tested before the lock so the supply bit shows.
            if (vpp_low) begin
              pst_ff[apart][`PF_S_VPP] <= 1'b1;
              pst_ff[apart][`PF_S_PERR] <= cmd == `PF_C_PROG;
              pst_ff[apart][`PF_S_EERR] <= cmd == `PF_C_ERASE;
            end else if (blk_lock || !blk_ok) begin
              pst_ff[apart][`PF_S_LOCK] <= 1'b1;
              pst_ff[apart][`PF_S_PERR] <= cmd == `PF_C_PROG;
              pst_ff[apart][`PF_S_EERR] <= cmd == `PF_C_ERASE;
            end else begin
              st_ff <= S_RUN;
              op_erase_ff <= cmd == `PF_C_ERASE;
              op_part_ff <= apart;
              arr_addr_o <= addr_ff;
              arr_wdata_o <= data_ff;
              arr_erase_param_o <= blk[3];
              tmr_ff <= cmd == `PF_C_ERASE ? ERASE_CYC : PROG_CYC;
              pst_ff[apart][`PF_S_READY] <= 1'b0;
            end
          end
        end
        S_RUN: begin
          // Suspend keeps the remaining count for the resume.
          if (wr_cmd && cmd == `PF_C_SUSP) begin
            st_ff <= S_SUSP;
            pst_ff[op_part_ff][`PF_S_READY] <= 1'b1;
            pst_ff[op_part_ff][`PF_S_ESUSP] <= op_erase_ff;
            pst_ff[op_part_ff][`PF_S_PSUSP] <= ~op_erase_ff;
          end else if (vpp_low) begin
            st_ff <= S_IDLE;
            pst_ff[op_part_ff][`PF_S_READY] <= 1'b1;
            pst_ff[op_part_ff][`PF_S_VPP] <= 1'b1;
            pst_ff[op_part_ff][`PF_S_EERR] <= op_erase_ff;
            pst_ff[op_part_ff][`PF_S_PERR] <= ~op_erase_ff;
          end else if (tmr_ff == `PF_TMR_LAST) begin
            st_ff <= S_IDLE;
            arr_prog_o <= ~op_erase_ff;
            arr_erase_o <= op_erase_ff;
            pst_ff[op_part_ff][`PF_S_READY] <= 1'b1;
          end else begin
            tmr_ff <= tmr_ff - `PF_TMR_LAST;
          end
        end
        S_SUSP: begin
          // Only resume leaves; the engine goes on from the kept count.
          if (wr_cmd && cmd == `PF_C_RESUME) begin
            st_ff <= S_RUN;
            pst_ff[op_part_ff][`PF_S_READY] <= 1'b0;
            pst_ff[op_part_ff][`PF_S_ESUSP] <= 1'b0;
            pst_ff[op_part_ff][`PF_S_PSUSP] <= 1'b0;
          end
        end
        default: begin
          st_ff <= S_IDLE;
        end
      endcase
    end
  end

  // Read port; array reads in a busy partition see its status instead.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h00000000;
    end else if (!rd_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      // Unmapped offsets read as zero.
      case (addr_i)
        `PF_R_ADDR: rdata_o <= {{(32-AW){1'b0}}, addr_ff};
        `PF_R_DATA: rdata_o <= {16'h0000, data_ff};
        `PF_R_STAT: rdata_o <= {16'h0000, 5'h00, st_ff, pst_ff[apart]};
        `PF_R_ARRAY: begin
          // A busy partition shows its status; others read the array.
          if (part_busy) begin
            rdata_o <= {24'h000000, pst_ff[apart]};
          end else begin
            rdata_o <= {16'h0000, arr_rdata_i};
          end
        end
        `PF_R_CFG: rdata_o <= {31'h00000000, burst_ff};
        `PF_R_LOCK: rdata_o <= {29'h00000000, blk_ok, ldn_ff[blk],
                                blk_lock};
        `PF_R_PIDX: rdata_o <= {29'h00000000, pidx_ff};
        `PF_R_PDATA: begin
          if (pidx_ff[2]) begin
            rdata_o <= {16'h0000, prot_ff[pidx_ff[1:0]]};
          end else begin
            rdata_o <= {16'h0000, UID[pidx_ff[1:0]*16 +: 16]};
          end
        end
        default: rdata_o <= 32'h00000000;
      endcase
    end
  end

  // Burst latency count on host clock edges drives the wait output.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lat_ff <= 8'h00;
      wait_o <= 1'b0;
    end else if (!burst_ff || !rd_act) begin
      lat_ff <= 8'h00;
      wait_o <= 1'b0;
    end else begin
      // Count host clock rises; wait drops once the latency is met.
      if (bedge && lat_ff != BURST_LAT[7:0]) begin
        lat_ff <= lat_ff + 8'h01;
      end
      wait_o <= lat_ff != BURST_LAT[7:0];
    end
  end

  // Power saving after a read cycle ends and standby from chip selects.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      auto_power_saving_o <= 1'b0;
      flash_standby_o <= 1'b1;
      sram_standby_o <= 1'b1;
    end else begin
      // Standby follows the synchronised selects.
      flash_standby_o <= s2_ff[`PF_P_CE];
      sram_standby_o <= s2_ff[`PF_P_CS1] | ~s2_ff[`PF_P_CS2];
      // An active read wakes the flash; the end of one puts it to sleep.
      if (rd_act) begin
        auto_power_saving_o <= 1'b0;
      end else if (s2_ff[`PF_P_OE] && !oe_d_ff) begin
        auto_power_saving_o <= 1'b1;
      end
    end
  end
endmodule // pfa_ctrl

// ### pfa_host.sv
// Host pin model: flash selects and the burst clock of a read frame.
module pfa_host (
  input wire logic frame_i,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic bclk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // The burst clock only runs inside a frame and rests low between frames.
  initial begin
    bclk_o = 1'b0;
    forever begin
      #160;
      bclk_o = frame_i ? ~bclk_o : 1'b0;
    end
  end
  // Selects are only driven active for the length of a frame.
  assign ce_n_o = ~frame_i;
  assign oe_n_o = ~frame_i;
endmodule // pfa_host

// ### pfa_ctrl_props.sv
// Concurrent checks on the pins of the flash array control.
module pfa_ctrl_chk (
  input wire clk_i,
  input wire rst_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire arr_prog_o,
  input wire arr_erase_o,
  input wire ce_n_i,
  input wire oe_n_i,
  input wire sram_cs1_n_i,
  input wire sram_cs2_i,
  input wire vpp_ok_i,
  input wire wait_o,
  input wire auto_power_saving_o,
  input wire flash_standby_o,
  input wire sram_standby_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  flash_sb_a: assert property (
    $stable(ce_n_i)[*4] |-> flash_standby_o == ce_n_i)
    else $error("flash standby does not follow its select");
  sram_sb_a: assert property (
    ($stable(sram_cs1_n_i) && $stable(sram_cs2_i))[*4]
    |-> sram_standby_o == (sram_cs1_n_i | ~sram_cs2_i))
    else $error("sram standby does not follow its selects");
  rdata_idle_a: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside the answer cycle");
  op_excl_a: assert property (
    !(arr_prog_o && arr_erase_o))
    else $error("program and erase completed together");
  vpp_lock_a: assert property (
    (!vpp_ok_i)[*5] |-> !arr_prog_o && !arr_erase_o)
    else $error("array changed with supply below lockout");
  wait_desel_a: assert property (
    ce_n_i[*4] |-> !wait_o)
    else $error("wait raised while deselected");
  aps_set_a: assert property (
    $rose(oe_n_i) ##1 oe_n_i[*4] |-> auto_power_saving_o)
    else $error("no power saving after a read cycle");
  aps_clr_a: assert property (
    (!ce_n_i && !oe_n_i)[*4] |-> !auto_power_saving_o)
    else $error("power saving during an active read");
endmodule // pfa_ctrl_chk
bind pfa_ctrl pfa_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .arr_prog_o(arr_prog_o), .arr_erase_o(arr_erase_o),
  .ce_n_i(ce_n_i), .oe_n_i(oe_n_i), .sram_cs1_n_i(sram_cs1_n_i),
  .sram_cs2_i(sram_cs2_i), .vpp_ok_i(vpp_ok_i), .wait_o(wait_o),
  .auto_power_saving_o(auto_power_saving_o),
  .flash_standby_o(flash_standby_o), .sram_standby_o(sram_standby_o));

// ### pfa_ctrl_tb.sv
// Self-checking bench of the flash array control with a host pin model.
`include "pfa_map.vh"
module pfa_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [63:0] UIDV = 64'h5A5A1111C3C32222; // Arbitrary value.
  localparam [31:0] P0 = 32'h0;
  localparam [31:0] P1 = 32'h40000;
  localparam [31:0] P2 = 32'h80000;
  localparam [31:0] PAR = 32'h1FB000;
  localparam [31:0] MN = 32'h50000;
  logic clk_i, rst_i, wr_i, rd_i, wp_n, vpp, frame;
  logic cs1_n = 1'b1;
  logic cs2 = 1'b0;
  logic ce_n, oe_n, bclk;
  logic [5:0] addr_i;
  logic [31:0] wdata_i, rdata_o, q[$], seed;
  logic [15:0] ar, dat, wd;
  logic [20:0] aa;
  logic rd_d = 1'b0;
  logic prg, ers, par, wt, auto_power_saving, fsb, ssb;
  int err_count = 0, samples_checked = 0, rises = 0, cnt = 0;
  int r0 = 0;
  pfa_host host (.frame_i(frame), .ce_n_o(ce_n), .oe_n_o(oe_n),
    .bclk_o(bclk));
  pfa_ctrl #(.PROG_CYC(5), .ERASE_CYC(10), .UID(UIDV)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .arr_rdata_i(ar), .arr_addr_o(aa),
    .arr_wdata_o(wd), .arr_prog_o(prg), .arr_erase_o(ers),
    .arr_erase_param_o(par), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .sram_cs1_n_i(cs1_n), .sram_cs2_i(cs2), .wp_n_i(wp_n), .vpp_ok_i(vpp),
    .bclk_i(bclk), .wait_o(wt), .auto_power_saving_o(auto_power_saving),
    .flash_standby_o(fsb), .sram_standby_o(ssb));
  // Free-running system clock.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Counts burst clock edges and stirs the sram selects now and then.
  always @(posedge bclk) rises++;
  always @(posedge clk_i) begin
    cnt++;
    if (cnt % 8 == 0) {cs1_n, cs2} <= 2'($random(seed));
    rd_d <= rd_i;
  end
  // Takes the oldest expected read value when the answer cycle comes.
  always @(negedge clk_i) begin
    if (rd_d && q.size() > 0) begin
      check(rdata_o, q.pop_front());
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_reg(input logic [5:0] a, input logic [31:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    wr_i <= 1'b0;
    q.push_back(e);
    @(posedge clk_i);
  endtask
  task automatic idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask
  // Waits for completion pulses or a wait level, with a bound.
  task automatic wait_for(input int s);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    while (n < 60 && !hit) begin
      @(posedge clk_i);
      #1;
      n++;
      case (s)
        0: hit = prg === 1'b1;
        1: hit = ers === 1'b1;
        2: hit = wt === 1'b1;
        default: hit = wt === 1'b0;
      endcase
    end
    if (!hit) begin
      err_count++;
      test_done();
    end
  endtask
  task automatic test_done();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence of scenarios.
  initial begin
    seed = 32'hA334;
    {rst_i, wr_i, rd_i, addr_i, wdata_i} = {3'b100, 38'h0};
    {wp_n, vpp, frame} = 3'b110;
    ar = 16'($random(seed));
    dat = 16'($random(seed));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_reg(`PF_R_STAT, 32'h180);
    rd_reg(`PF_R_CFG, 32'h0);
    rd_reg(6'h24, 32'h0);
    wr_reg(`PF_R_ADDR, P2);
    wr_reg(`PF_R_CMD, `PF_C_PROG);
    idle(2);
    rd_reg(`PF_R_STAT, 32'h192);
    wr_reg(`PF_R_CMD, `PF_C_CLRST);
    wr_reg(`PF_R_ADDR, P0);
    wr_reg(`PF_R_DATA, {16'h0, dat});
    wr_reg(`PF_R_CMD, `PF_C_UNLOCK);
    rd_reg(`PF_R_LOCK, 32'h4);
    wr_reg(`PF_R_CMD, `PF_C_PROG);
    rd_reg(`PF_R_ARRAY, 32'h0);
    wr_reg(`PF_R_ADDR, P1);
    rd_reg(`PF_R_ARRAY, {16'h0, ar});
    wait_for(0);
    check({11'h0, aa}, P0);
    check({16'h0, wd}, {16'h0, dat});
    wr_reg(`PF_R_ADDR, P0);
    rd_reg(`PF_R_STAT, 32'h180);
    vpp <= 1'b0;
    idle(4);
    rd_reg(`PF_R_LOCK, 32'h5);
    wr_reg(`PF_R_CMD, `PF_C_PROG);
    idle(2);
    rd_reg(`PF_R_ARRAY, {16'h0, ar});
    vpp <= 1'b1;
    wr_reg(`PF_R_ADDR, PAR);
    wr_reg(`PF_R_CMD, `PF_C_UNLOCK);
    wr_reg(`PF_R_CMD, `PF_C_ERASE);
    wait_for(1);
    check({31'h0, par}, 32'h1);
    check({11'h0, aa}, PAR);
    wr_reg(`PF_R_ADDR, MN);
    wr_reg(`PF_R_CMD, `PF_C_UNLOCK);
    wr_reg(`PF_R_CMD, `PF_C_ERASE);
    wr_reg(`PF_R_CMD, `PF_C_SUSP);
    idle(1);
    rd_reg(`PF_R_ARRAY, {16'h0, ar});
    wr_reg(`PF_R_CMD, `PF_C_RESUME);
    wait_for(1);
    check({31'h0, par}, 32'h0);
    wr_reg(`PF_R_CMD, `PF_C_LOCKDN);
    wp_n <= 1'b0;
    idle(4);
    wr_reg(`PF_R_CMD, `PF_C_UNLOCK);
    rd_reg(`PF_R_LOCK, 32'h7);
    wp_n <= 1'b1;
    idle(4);
    wr_reg(`PF_R_CMD, `PF_C_UNLOCK);
    rd_reg(`PF_R_LOCK, 32'h6);
    wr_reg(`PF_R_PIDX, 32'h0);
    rd_reg(`PF_R_PDATA, {16'h0, UIDV[15:0]});
    wr_reg(`PF_R_PIDX, 32'h4);
    rd_reg(`PF_R_PDATA, 32'hFFFF);
    wr_reg(`PF_R_PDATA, 32'h1234);
    wr_reg(`PF_R_PDATA, 32'h5678);
    rd_reg(`PF_R_PDATA, 32'h1234);
    wr_reg(`PF_R_CFG, 32'h1);
    rd_reg(`PF_R_CFG, 32'h1);
    r0 = rises;
    frame <= 1'b1;
    wait_for(2);
    check({31'h0, auto_power_saving}, 32'h0);
    check({31'h0, fsb}, 32'h0);
    wait_for(3);
    check({31'h0, (rises - r0) >= 3}, 32'h1);
    frame <= 1'b0;
    idle(6);
    check({31'h0, auto_power_saving}, 32'h1);
    check({31'h0, fsb}, 32'h1);
    rst_i <= 1'b1;
    idle(3);
    rst_i <= 1'b0;
    rd_reg(`PF_R_CFG, 32'h0);
    idle(3);
    check(q.size(), 32'h0);
    test_done();
  end
endmodule // pfa_ctrl_tb
